// file: shared/rsc_pkg.sv
// Constants shared by the return stack and control instruction core.
// How it works
// RQ1 - Negate op replaces addressed byte with two's complement and sets N, OV, C, DC, Z.
// RQ2 - Negate op takes one cycle: read in phase two, write back in phase four.
// RQ3 - All-zero opcode or top nibble all ones is a one-cycle no-operation.
// RQ4 - Pop discards the stack top so the previous entry becomes top, no flags.
// RQ5 - Pop acts in phase three; phases two and four do nothing.
// RQ6 - Push writes program counter plus two as new stack top in phase two.
// RQ7 - Push keeps the previous stack top one level below the new entry.
// RQ8 - Relative call carries an 11-bit signed word offset, range -1024 to 1023.
// RQ9 - Relative call pushes program counter plus two before changing the counter.
// RQ10 - Relative call loads counter plus two plus twice offset, two cycles, no flags.
// RQ11 - Reset op clears everything a master clear clears, starting in phase two.
// RQ12 - Interrupt return pops the stack into the counter in phase four, two cycles.
// RQ13 - Interrupt return sets the high or low enable of the exited level.
// RQ14 - Interrupt return with fast bit set restores accumulator, flags, bank from shadows.
// RQ15 - Literal return loads the literal into the accumulator and pops the counter.
// RQ16 - Literal return keeps both counter latches, no flags, two cycles, work in phase four.
// RQ17 - Literal return takes the counter from the stack top, the saved return address.
package rsc_pkg;
  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_PC = 8'h08;
  localparam logic [7:0] OFS_WREG = 8'h0c;
  localparam logic [7:0] OFS_FLAGS = 8'h10;
  localparam logic [7:0] OFS_BANK = 8'h14;
  localparam logic [7:0] OFS_WSH = 8'h18;
  localparam logic [7:0] OFS_FSH = 8'h1c;
  localparam logic [7:0] OFS_BSH = 8'h20;
  localparam logic [7:0] OFS_IRQ = 8'h24;
  localparam logic [7:0] OFS_TOP = 8'h28;
  localparam logic [7:0] OFS_SP = 8'h2c;
  localparam logic [7:0] OFS_DADDR = 8'h30;
  localparam logic [7:0] OFS_DATA = 8'h34;
  localparam logic [7:0] OFS_PCH = 8'h38;
  localparam logic [7:0] OFS_PCU = 8'h3c;
  localparam logic [7:0] OFS_LAST = 8'h3c;
  // ****************************************
  // Opcodes and masks
  // ****************************************
  localparam logic [15:0] OP_NOP = 16'h0000;
  localparam logic [15:0] OP_PUSH = 16'h0005;
  localparam logic [15:0] OP_POP = 16'h0006;
  localparam logic [15:0] OP_RESET = 16'h00ff;
  localparam logic [15:0] OP_IRET = 16'h0010;
  localparam logic [15:0] MSK_IRET = 16'hfffe;
  localparam logic [15:0] OP_LITRET = 16'h0c00;
  localparam logic [15:0] MSK_LITRET = 16'hff00;
  localparam logic [15:0] OP_NEG = 16'h6c00;
  localparam logic [15:0] MSK_NEG = 16'hfe00;
  localparam logic [15:0] OP_RELCALL = 16'hd800;
  localparam logic [15:0] MSK_RELCALL = 16'hf800;
  localparam logic [3:0] NOP_NIBBLE = 4'hf;
  // ****************************************
  // Fields, widths and reset values
  // ****************************************
  localparam int FLG_C = 0;
  localparam int FLG_DC = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_OV = 3;
  localparam int FLG_N = 4;
  localparam int IRQ_HIEN = 0;
  localparam int IRQ_LOEN = 1;
  localparam int IRQ_IPEN = 2;
  localparam int IRQ_INHI = 3;
  localparam int PC_W = 21;
  localparam int STK_AW = 5;
  localparam logic [4:0] STK_MAX = 5'h1f;
  localparam logic [20:0] PC_STEP = 21'h000002;
  localparam logic [20:0] RST_PC = 21'h000000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// file: rtl/rsc_mem.sv
// Small single-write memory with a registered read port.
`timescale 1ns/1ps
module rsc_mem #(
  parameter int DW = 8,
  parameter int AW = 12
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Write port
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  // Read port
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem_q [2**AW];

  always_ff @(posedge ref_clk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= mem_q[raddr_i];
    end
  end
endmodule // rsc_mem

// file: rtl/rsc_neg.sv
// Two's complement negation of a data byte with its flag results.
`timescale 1ns/1ps
module rsc_neg (
  // Operand
  input wire logic [7:0] opnd_i,
  // Result and flags
  output logic [7:0] res_o,
  output logic [4:0] flags_o
);
  always_comb begin
    res_o = 8'(~opnd_i + 8'h01);
    flags_o = '0;
    // Carry out of the inverted operand plus one only happens for a zero operand.
    flags_o[rsc_pkg::FLG_C] = (opnd_i == 8'h00);
    flags_o[rsc_pkg::FLG_DC] = (opnd_i[3:0] == 4'h0);
    flags_o[rsc_pkg::FLG_Z] = (res_o == 8'h00);
    flags_o[rsc_pkg::FLG_OV] = (opnd_i == 8'h80);
    flags_o[rsc_pkg::FLG_N] = res_o[7];
  end
endmodule // rsc_neg

// file: rtl/rsc_core.sv
// Execution core for stack and control instructions behind an AXI4-Lite slave.
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module rsc_core #(
  parameter int PHASE_DIV = 1,
  parameter int DATA_AW = 12
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Status
  output logic busy_o
);
  typedef enum logic [1:0] {ST_IDLE, ST_CYC1, ST_CYC2} rsc_state_type;

  rsc_state_type st_q;
  logic [1:0] phase_q;
  logic [7:0] div_q;
  logic [3:0] ticks_q;
  logic [15:0] op_q;
  logic [20:0] pc_q;
  logic [7:0] w_q, wsh_q, pch_q, pcu_q;
  logic [4:0] flags_q, fsh_q, sp_q;
  logic [3:0] bank_q, bsh_q, irq_q;
  logic [DATA_AW-1:0] daddr_q;
  logic aw_have_q, w_have_q;
  logic [7:0] aw_addr_q;
  logic [31:0] wdata_q, wmerged;
  logic [3:0] wstrb_q;
  logic busy, q_tick, ev_q2, ev_q3, ev_q4, ev_end, core_clr;
  logic is_nop, is_push, is_pop, is_reset, is_iret, is_litret, is_neg, is_relcall, two_cyc;
  logic wr_fire, wr_ok, start, push_ev, pop_ev;
  logic [20:0] stk_rdata, top, relcall_tgt;
  logic [7:0] dm_rdata, dm_wdata, neg_res;
  logic [4:0] neg_flags;
  logic [DATA_AW-1:0] neg_addr, dm_addr;
  logic dm_we;

  // ****************************************
  // Decode and phase sequencing
  // ****************************************
  assign is_nop = (op_q == rsc_pkg::OP_NOP) || (op_q[15:12] == rsc_pkg::NOP_NIBBLE); // [RQ3]
  assign is_push = (op_q == rsc_pkg::OP_PUSH);
  assign is_pop = (op_q == rsc_pkg::OP_POP);
  assign is_reset = (op_q == rsc_pkg::OP_RESET);
  assign is_iret = ((op_q & rsc_pkg::MSK_IRET) == rsc_pkg::OP_IRET);
  assign is_litret = ((op_q & rsc_pkg::MSK_LITRET) == rsc_pkg::OP_LITRET);
  assign is_neg = ((op_q & rsc_pkg::MSK_NEG) == rsc_pkg::OP_NEG);
  assign is_relcall = ((op_q & rsc_pkg::MSK_RELCALL) == rsc_pkg::OP_RELCALL);
  assign two_cyc = is_relcall || is_iret || is_litret; // [RQ10] [RQ12] [RQ16]
  assign busy = (st_q != ST_IDLE);
  assign busy_o = busy;
  assign q_tick = busy && (div_q == 8'(PHASE_DIV - 1));
  assign ev_q2 = q_tick && (st_q == ST_CYC1) && (phase_q == 2'd1);
  assign ev_q3 = q_tick && (st_q == ST_CYC1) && (phase_q == 2'd2);
  assign ev_q4 = q_tick && (st_q == ST_CYC1) && (phase_q == 2'd3);
  assign ev_end = q_tick && (phase_q == 2'd3) && ((st_q == ST_CYC2) || !two_cyc);
  assign core_clr = rst_i || (ev_q2 && is_reset); // [RQ11]
  assign start = wr_fire && (aw_addr_q == rsc_pkg::OFS_INSTR) && !busy;

  always_ff @(posedge ref_clk_i) begin
    if (core_clr || !busy || q_tick) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (core_clr) begin
      st_q <= ST_IDLE;
      phase_q <= 2'd0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          phase_q <= 2'd0;
          if (start) begin
            st_q <= ST_CYC1;
          end
        end
        ST_CYC1, ST_CYC2: begin
          if (q_tick) begin
            phase_q <= phase_q + 2'd1;
            if (phase_q == 2'd3) begin
              st_q <= (st_q == ST_CYC1 && two_cyc) ? ST_CYC2 : ST_IDLE;
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (core_clr) begin
      op_q <= rsc_pkg::OP_NOP;
    end else if (start) begin
      op_q <= wdata_q[15:0];
    end
  end

  // ****************************************
  // Program counter and return stack
  // ****************************************
  // Sign-extended word offset doubled into a byte offset.
  assign relcall_tgt = pc_q + rsc_pkg::PC_STEP + {{9{op_q[10]}}, op_q[10:0], 1'b0}; // [RQ8] [RQ10]
  assign top = (sp_q == 5'h00) ? rsc_pkg::RST_PC : stk_rdata;
  // A push at full depth or a pop when empty is dropped rather than wrapping.
  assign push_ev = ev_q2 && (is_push || is_relcall) && (sp_q != rsc_pkg::STK_MAX); // [RQ6] [RQ9]
  assign pop_ev = ((ev_q3 && is_pop) || (ev_q4 && (is_iret || is_litret))) && (sp_q != 5'h00); // [RQ4] [RQ5]

  always_ff @(posedge ref_clk_i) begin
    if (core_clr) begin
      sp_q <= 5'h00;
    end else if (push_ev) begin
      sp_q <= sp_q + 5'h01;
    end else if (pop_ev) begin
      sp_q <= sp_q - 5'h01;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (core_clr) begin
      pc_q <= rsc_pkg::RST_PC;
    end else if (wr_ok && aw_addr_q == rsc_pkg::OFS_PC) begin
      pc_q <= wmerged[20:0];
    end else if (ev_q4) begin
      if (is_relcall) begin
        pc_q <= relcall_tgt; // [RQ10]
      end else if (is_iret || is_litret) begin
        pc_q <= top; // [RQ12] [RQ17]
      end else begin
        pc_q <= pc_q + rsc_pkg::PC_STEP;
      end
    end
  end

  // The new entry goes one slot above the old top, which stays intact below it.
  rsc_mem #(
    .DW(rsc_pkg::PC_W),
    .AW(rsc_pkg::STK_AW)
  ) u_stack (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .we_i(push_ev),
    .waddr_i(sp_q + 5'h01), // [RQ7]
    .wdata_i(pc_q + rsc_pkg::PC_STEP),
    .raddr_i(sp_q),
    .rdata_o(stk_rdata)
  );

  // ****************************************
  // Working registers
  // ****************************************
  always_ff @(posedge ref_clk_i) begin
    if (core_clr) begin
      w_q <= rsc_pkg::RST_BYTE;
    end else if (wr_ok && aw_addr_q == rsc_pkg::OFS_WREG) begin
      w_q <= wmerged[7:0];
    end else if (ev_q4 && is_litret) begin
      w_q <= op_q[7:0]; // [RQ15]
    end else if (ev_q4 && is_iret && op_q[0]) begin
      w_q <= wsh_q; // [RQ14]
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (core_clr) begin
      flags_q <= 5'h00;
      bank_q <= 4'h0;
    end else if (wr_ok && aw_addr_q == rsc_pkg::OFS_FLAGS) begin
      flags_q <= wmerged[4:0];
    end else if (wr_ok && aw_addr_q == rsc_pkg::OFS_BANK) begin
      bank_q <= wmerged[3:0];
    end else if (ev_q4 && is_neg) begin
      flags_q <= neg_flags; // [RQ1]
    end else if (ev_q4 && is_iret && op_q[0]) begin
      flags_q <= fsh_q; // [RQ14]
      bank_q <= bsh_q;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (core_clr) begin
      wsh_q <= rsc_pkg::RST_BYTE;
      fsh_q <= 5'h00;
      bsh_q <= 4'h0;
      pch_q <= rsc_pkg::RST_BYTE;
      pcu_q <= rsc_pkg::RST_BYTE;
      daddr_q <= '0;
    end else if (wr_ok) begin
      case (aw_addr_q)
        rsc_pkg::OFS_WSH: wsh_q <= wmerged[7:0];
        rsc_pkg::OFS_FSH: fsh_q <= wmerged[4:0];
        rsc_pkg::OFS_BSH: bsh_q <= wmerged[3:0];
        rsc_pkg::OFS_PCH: pch_q <= wmerged[7:0]; // [RQ16]
        rsc_pkg::OFS_PCU: pcu_q <= wmerged[7:0];
        rsc_pkg::OFS_DADDR: daddr_q <= wmerged[DATA_AW-1:0];
        default: begin
        end
      endcase
    end
  end

  // Leaving high level, or with priorities off, re-arms the global enable.
  always_ff @(posedge ref_clk_i) begin
    if (core_clr) begin
      irq_q <= 4'h0;
    end else if (wr_ok && aw_addr_q == rsc_pkg::OFS_IRQ) begin
      irq_q <= wmerged[3:0];
    end else if (ev_q4 && is_iret) begin
      if (!irq_q[rsc_pkg::IRQ_IPEN] || irq_q[rsc_pkg::IRQ_INHI]) begin
        irq_q[rsc_pkg::IRQ_HIEN] <= 1'b1; // [RQ13]
        irq_q[rsc_pkg::IRQ_INHI] <= 1'b0;
      end else begin
        irq_q[rsc_pkg::IRQ_LOEN] <= 1'b1; // [RQ13]
      end
    end
  end

  // ****************************************
  // Data memory and negation
  // ****************************************
  assign neg_addr = op_q[8] ? DATA_AW'({bank_q, op_q[7:0]}) :
                    (op_q[7:0] < rsc_pkg::ACCESS_SPLIT) ? DATA_AW'({4'h0, op_q[7:0]}) :
                    DATA_AW'({rsc_pkg::ACCESS_HI_BANK, op_q[7:0]});
  // The operand is addressed from the first phase so its byte is ready by the second.
  assign dm_addr = busy ? neg_addr : daddr_q; // [RQ2]
  assign dm_we = (ev_q4 && is_neg) || (wr_ok && aw_addr_q == rsc_pkg::OFS_DATA); // [RQ2]
  assign dm_wdata = busy ? neg_res : wmerged[7:0];

  rsc_neg u_neg (
    .opnd_i(dm_rdata),
    .res_o(neg_res),
    .flags_o(neg_flags)
  );

  rsc_mem #(
    .DW(8),
    .AW(DATA_AW)
  ) u_data (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .we_i(dm_we),
    .waddr_i(dm_addr),
    .wdata_i(dm_wdata),
    .raddr_i(dm_addr),
    .rdata_o(dm_rdata)
  );

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  function automatic logic [31:0] reg_word(input logic [7:0] a);
    case (a)
      rsc_pkg::OFS_INSTR: reg_word = 32'(op_q);
      rsc_pkg::OFS_STAT: reg_word = 32'(busy);
      rsc_pkg::OFS_PC: reg_word = 32'(pc_q);
      rsc_pkg::OFS_WREG: reg_word = 32'(w_q);
      rsc_pkg::OFS_FLAGS: reg_word = 32'(flags_q);
      rsc_pkg::OFS_BANK: reg_word = 32'(bank_q);
      rsc_pkg::OFS_WSH: reg_word = 32'(wsh_q);
      rsc_pkg::OFS_FSH: reg_word = 32'(fsh_q);
      rsc_pkg::OFS_BSH: reg_word = 32'(bsh_q);
      rsc_pkg::OFS_IRQ: reg_word = 32'(irq_q);
      rsc_pkg::OFS_TOP: reg_word = 32'(top);
      rsc_pkg::OFS_SP: reg_word = 32'(sp_q);
      rsc_pkg::OFS_DADDR: reg_word = 32'(daddr_q);
      rsc_pkg::OFS_DATA: reg_word = 32'(dm_rdata);
      rsc_pkg::OFS_PCH: reg_word = 32'(pch_q);
      rsc_pkg::OFS_PCU: reg_word = 32'(pcu_q);
      default: reg_word = 32'h00000000;
    endcase
  endfunction

  always_comb begin
    wmerged = reg_word(aw_addr_q);
    for (int i = 0; i < 4; i++) begin
      if (wstrb_q[i]) begin
        wmerged[8*i +: 8] = wdata_q[8*i +: 8];
      end
    end
  end

  assign s_axi_awready_o = !aw_have_q;
  assign s_axi_wready_o = !w_have_q;
  assign s_axi_arready_o = !s_axi_rvalid_o;
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid_o;
  // Register writes cannot touch a running instruction's state; they are dropped, not queued.
  assign wr_ok = wr_fire && !busy;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || wr_fire) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
    end else begin
      if (s_axi_awvalid_i && !aw_have_q) begin
        aw_have_q <= 1'b1;
      end
      if (s_axi_wvalid_i && !w_have_q) begin
        w_have_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      aw_addr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid_i && !aw_have_q) begin
        aw_addr_q <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && !w_have_q) begin
        wdata_q <= s_axi_wdata_i;
        wstrb_q <= s_axi_wstrb_i;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= rsc_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= (aw_addr_q[1:0] == 2'b00 && aw_addr_q <= rsc_pkg::OFS_LAST) ?
                       rsc_pkg::RESP_OKAY : rsc_pkg::RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h00000000;
      s_axi_rresp_o <= rsc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_i && !s_axi_rvalid_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= reg_word(s_axi_araddr_i);
      s_axi_rresp_o <= (s_axi_araddr_i[1:0] == 2'b00 && s_axi_araddr_i <= rsc_pkg::OFS_LAST) ?
                       rsc_pkg::RESP_OKAY : rsc_pkg::RESP_SLVERR;
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  always_ff @(posedge ref_clk_i) begin
    if (core_clr || !busy) begin
      ticks_q <= 4'h0;
    end else if (q_tick) begin
      ticks_q <= ticks_q + 4'h1;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  property p_neg_value;
    ev_q4 && is_neg |-> dm_we && dm_wdata == 8'(8'h00 - dm_rdata) ##1 flags_q[rsc_pkg::FLG_Z] == ($past(dm_rdata) == 8'h00);
  endproperty
  a_neg_value: assert property (p_neg_value) else $error("negate result or zero flag wrong"); // [RQ1]
  property p_one_cycle;
    ev_end && (is_neg || is_push || is_pop || is_nop) |-> ticks_q == 4'h3;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("single cycle op ran wrong length"); // [RQ2]
  property p_nop_quiet;
    busy && is_nop && !ev_end |=> $stable(w_q) && $stable(sp_q) && $stable(flags_q) && $stable(bank_q);
  endproperty
  a_nop_quiet: assert property (p_nop_quiet) else $error("no-operation changed state"); // [RQ3]
  property p_pop;
    ev_q3 && is_pop && sp_q != 5'h00 |=> sp_q == $past(sp_q) - 5'h01 ##1 $stable(sp_q);
  endproperty
  a_pop: assert property (p_pop) else $error("pop did not drop one level in phase three"); // [RQ5]
  property p_push;
    ev_q2 && is_push && sp_q != rsc_pkg::STK_MAX |=> sp_q == $past(sp_q) + 5'h01 ##1 top == $past(pc_q, 2) + 21'h000002;
  endproperty
  a_push: assert property (p_push) else $error("push did not place counter plus two on top"); // [RQ6]
  property p_relcall;
    ev_q4 && is_relcall |=> pc_q == $past(pc_q) + 21'h000002 + {{9{op_q[10]}}, op_q[10:0], 1'b0};
  endproperty
  a_relcall: assert property (p_relcall) else $error("relative call target wrong"); // [RQ10]
  property p_two_cycle;
    ev_end && two_cyc |-> ticks_q == 4'h7 && $stable(flags_q);
  endproperty
  a_two_cycle: assert property (p_two_cycle) else $error("two cycle op ran wrong length"); // [RQ10]
  property p_soft_reset;
    ev_q2 && is_reset |=> st_q == ST_IDLE && w_q == 8'h00 && sp_q == 5'h00 && pc_q == 21'h000000;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("reset op did not clear the core"); // [RQ11]
  property p_iret;
    ev_q4 && is_iret |=> pc_q == $past(top) && (irq_q[rsc_pkg::IRQ_HIEN] || irq_q[rsc_pkg::IRQ_LOEN]);
  endproperty
  a_iret: assert property (p_iret) else $error("interrupt return pc or enable wrong"); // [RQ12]
  property p_fast;
    ev_q4 && is_iret && op_q[0] |=> w_q == $past(wsh_q) && bank_q == $past(bsh_q) && flags_q == $past(fsh_q);
  endproperty
  a_fast: assert property (p_fast) else $error("fast return did not restore shadows"); // [RQ14]
  property p_litret;
    ev_q4 && is_litret |=> w_q == $past(op_q[7:0]) && pc_q == $past(top) && $stable(pch_q) && $stable(pcu_q);
  endproperty
  a_litret: assert property (p_litret) else $error("literal return wrong"); // [RQ15]

  c_neg: cover property (ev_end && is_neg);
  c_relcall: cover property (ev_end && is_relcall);
  c_fast: cover property (ev_q4 && is_iret && op_q[0]);
  c_reset: cover property (ev_q2 && is_reset);
endmodule // rsc_core

// file: tb/return_stack_control_ops_tb.sv
// Self-checking testbench for the stack and control instruction core.
`timescale 1ns/1ps
module return_stack_control_ops_tb;
  // ****************************************
  // Signals and stimulus table
  // ****************************************
  typedef struct packed {
    logic [7:0] wa;
    logic [31:0] wd;
    logic [7:0] ra;
    logic [31:0] ex;
  } rsc_row_type;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rdv;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, busy;
  logic [1:0] bresp, rresp, rsp;
  int n_errors = 0, samples_checked = 0;
  // An address of 8'hff means the row only reads back.
  rsc_row_type rows [0:21] = '{
    '{rsc_pkg::OFS_INSTR, 32'h5, rsc_pkg::OFS_TOP, 32'h2}, '{rsc_pkg::OFS_INSTR, 32'h5, rsc_pkg::OFS_SP, 32'h2},
    '{rsc_pkg::OFS_INSTR, 32'h6, rsc_pkg::OFS_TOP, 32'h2}, '{rsc_pkg::OFS_INSTR, 32'hdffe, rsc_pkg::OFS_PC, 32'h4},
    '{8'hff, 32'h0, rsc_pkg::OFS_TOP, 32'h8}, '{rsc_pkg::OFS_PCH, 32'h12, rsc_pkg::OFS_PCH, 32'h12},
    '{rsc_pkg::OFS_INSTR, 32'hc5a, rsc_pkg::OFS_WREG, 32'h5a}, '{8'hff, 32'h0, rsc_pkg::OFS_PC, 32'h8},
    '{8'hff, 32'h0, rsc_pkg::OFS_PCH, 32'h12}, '{rsc_pkg::OFS_INSTR, 32'hf123, rsc_pkg::OFS_PC, 32'ha},
    '{rsc_pkg::OFS_WSH, 32'h77, rsc_pkg::OFS_WSH, 32'h77}, '{rsc_pkg::OFS_INSTR, 32'h11, rsc_pkg::OFS_WREG, 32'h77},
    '{8'hff, 32'h0, rsc_pkg::OFS_IRQ, 32'h1}, '{8'hff, 32'h0, rsc_pkg::OFS_PC, 32'h2},
    '{rsc_pkg::OFS_DADDR, 32'h10, rsc_pkg::OFS_DADDR, 32'h10}, '{rsc_pkg::OFS_DATA, 32'h3a, rsc_pkg::OFS_DATA, 32'h3a},
    '{rsc_pkg::OFS_INSTR, 32'h6c10, rsc_pkg::OFS_DATA, 32'hc6}, '{rsc_pkg::OFS_INSTR, 32'hdbff, rsc_pkg::OFS_PC, 32'h804},
    '{rsc_pkg::OFS_INSTR, 32'hff, rsc_pkg::OFS_PC, 32'h0}, '{8'hff, 32'h0, rsc_pkg::OFS_SP, 32'h0},
    '{8'hff, 32'h0, rsc_pkg::OFS_IRQ, 32'h0}, '{rsc_pkg::OFS_INSTR, 32'h0, rsc_pkg::OFS_PC, 32'h2}};

  rsc_core #(.PHASE_DIV(1), .DATA_AW(12)) uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .busy_o(busy));

  initial forever #20 ref_clk_i = ~ref_clk_i;

  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    // Ready stays high after the answer so it is never lowered and raised in one step.
    rsp = bresp;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rdv = rdata;
    rsp = rresp;
  endtask
  // Executing instructions drop register writes, so each table row write waits for idle after it.
  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      axi_rd(rsc_pkg::OFS_STAT);
      k++;
    end while (rdv[0] !== 1'b0 && k < 50);
    chk("idle", {31'h0, rdv[0]}, 32'h0);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    n_errors++;
    stop_test();
  end
  initial begin
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    axi_rd(rsc_pkg::OFS_PC);
    chk("reset pc", rdv, 32'h0);
    axi_rd(rsc_pkg::OFS_SP);
    chk("reset sp", rdv, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 22; i++) begin
      if (rows[i].wa !== 8'hff) begin
        axi_wr(rows[i].wa, rows[i].wd);
        wait_idle();
      end
      axi_rd(rows[i].ra);
      chk($sformatf("row %0d", i), rdv, rows[i].ex);
      $display("test row %0d done", i);
    end
    axi_rd(8'h40);
    chk("unmapped resp", {30'h0, rsp}, {30'h0, rsc_pkg::RESP_SLVERR});
    axi_wr(8'h02, 32'h0);
    chk("unaligned resp", {30'h0, rsp}, {30'h0, rsc_pkg::RESP_SLVERR});
    $display("test bad address done");
    // A push issued while the two-cycle call still runs must be dropped.
    axi_wr(rsc_pkg::OFS_INSTR, 32'hd800);
    chk("busy", {31'h0, busy}, 32'h1);
    axi_wr(rsc_pkg::OFS_INSTR, 32'h5);
    wait_idle();
    axi_rd(rsc_pkg::OFS_SP);
    chk("sp", rdv, 32'h1);
    axi_rd(rsc_pkg::OFS_TOP);
    chk("top", rdv, 32'h4);
    axi_rd(rsc_pkg::OFS_PC);
    chk("pc", rdv, 32'h4);
    $display("test busy refusal done");
    // Leaving a low-level handler re-arms only the low enable; a plain return keeps the accumulator.
    axi_wr(rsc_pkg::OFS_IRQ, 32'h4);
    axi_wr(rsc_pkg::OFS_INSTR, 32'h10);
    wait_idle();
    axi_rd(rsc_pkg::OFS_IRQ);
    chk("low enable", rdv, 32'h6);
    axi_rd(rsc_pkg::OFS_PC);
    chk("return pc", rdv, 32'h4);
    axi_rd(rsc_pkg::OFS_WREG);
    chk("plain return w", rdv, 32'h0);
    $display("test low level return done");
    // A reset in mid-instruction must abandon the push and clear the core.
    axi_wr(rsc_pkg::OFS_INSTR, 32'h5);
    rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    chk("reset busy", {31'h0, busy}, 32'h0);
    axi_rd(rsc_pkg::OFS_SP);
    chk("mid reset sp", rdv, 32'h0);
    axi_rd(rsc_pkg::OFS_PC);
    chk("mid reset pc", rdv, 32'h0);
    $display("test mid-run reset done");
    stop_test();
  end
endmodule // return_stack_control_ops_tb
